// ---- pkg/timer_channel_pkg.sv ----
// package for the single timer channel with pulse capture:
// register offsets, reset values, field layouts and mode encodings.
// assumes a 32-bit AXI4-Lite slave, one aligned word per register.
package timer_channel_pkg;

    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] OUT_MODE_OFFSET = 8'h04;
    localparam logic [7:0] OUT_LEVEL_OFFSET = 8'h08;
    localparam logic [7:0] OUT_VALUE_OFFSET = 8'h0C;
    localparam logic [7:0] OUT_ENABLE_OFFSET = 8'h10;
    localparam logic [7:0] IN_FILTER_OFFSET = 8'h14;
    localparam logic [7:0] DATA_OFFSET = 8'h18;
    localparam logic [7:0] COUNT_OFFSET = 8'h1C;
    localparam logic [7:0] CONTROL_OFFSET = 8'h20;

    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] OUT_RESET = 16'h0000;
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // control word: bit 0 starts the channel, bit 1 stops it
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    // status read at the control offset: bit 0 counting, bit 1 waiting
    localparam int STAT_COUNT_BIT = 0;
    localparam int STAT_WAIT_BIT = 1;

    // matching samples the noise filter needs before accepting a level
    localparam logic [1:0] FILTER_SAMPLES = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_INTERVAL = 3'h0,
        MODE_CAPTURE = 3'h2,
        MODE_EVENT = 3'h3,
        MODE_ONE_COUNT = 3'h4,
        MODE_CAPTURE_ONE = 3'h6
    } op_mode_type;

    typedef enum logic [2:0] {
        TRIG_SOFTWARE = 3'h0,
        TRIG_VALID_EDGE = 3'h1,
        TRIG_BOTH_EDGES = 3'h2,
        TRIG_MASTER = 3'h5
    } trigger_type;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH_LOW = 2'h2,
        EDGE_BOTH_HIGH = 2'h3
    } edge_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_COUNT = 2'b11
    } chan_state_type;

    typedef struct packed {
        logic op_clock_select_hi;
        logic op_clock_select_lo;
        logic unused_13;
        logic count_clock_source;
        logic master;
        logic [2:0] trigger_select;
        logic [1:0] edge_select;
        logic [1:0] unused_5_4;
        logic [2:0] operating_mode_field;
        logic start_control_bit;
    } mode_type;

endpackage : timer_channel_pkg

// ---- verilog/timer_channel_pulse_capture.sv ----
// one timer channel: prescaled count clock, input edge triggers,
// interval / capture / event / one-count / capture plus one-count modes.
// assumes an AXI4-Lite master on aclk and an asynchronous input pin.
`timescale 1ns/1ps
module timer_channel_pulse_capture #(
    parameter int CHANNEL = 2,
    parameter int COUNT_WIDTH = 16,
    parameter int CK0_SHIFT = 1,
    parameter int CK1_SHIFT = 2,
    parameter int CK2_SHIFT = 3,
    parameter int CK3_SHIFT = 4
) (
    input wire logic aclk, // system clock, 100 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] awaddr, // write address
    input wire logic [2:0] awprot, // write protection, unused
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic [2:0] arprot, // read protection, unused
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic timer_input_pin, // asynchronous pulse input
    input wire logic master_irq_in, // master channel interrupt pulse
    output logic timer_out, // channel timer output pin
    output logic timer_irq, // channel interrupt, one-cycle pulse
    output logic master_irq_out // interrupt passed on as master
);

    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = '0;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = COUNT_WIDTH'(1);

    timer_channel_pkg::mode_type mode;
    logic [15:0] out_mode, out_level, out_value, out_enable;
    logic [7:0] in_filter;
    logic [COUNT_WIDTH-1:0] data, count, next_count;
    timer_channel_pkg::chan_state_type state, next_state;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_held, w_held, sw_start, sw_stop;
    logic [15:0] presc;
    logic [2:0] pin_sync;
    logic in_level, in_prev;
    logic [1:0] filt_cnt;
    logic rise, fall, valid_edge, start_edge, capture_edge;
    logic start_trig, capture_trig, op_tick, count_tick;
    logic evt_irq, evt_toggle, evt_set, evt_clear, do_capture;
    logic [31:0] wr_word, rd_word;
    logic rd_ok;
    timer_channel_pkg::op_mode_type op_mode;
    timer_channel_pkg::trigger_type trig_sel;
    timer_channel_pkg::edge_type edge_sel;

    assign op_mode = timer_channel_pkg::op_mode_type'(mode.operating_mode_field);
    assign trig_sel = timer_channel_pkg::trigger_type'(mode.trigger_select);
    assign edge_sel = timer_channel_pkg::edge_type'(mode.edge_select);

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic tick_at(input logic [15:0] cnt, input int sh);
        logic [15:0] mask;
        mask = 16'((32'h1 << sh) - 1);
        return (cnt & mask) == mask;
    endfunction : tick_at

    // write channel: address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= timer_channel_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
                aw_held <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                w_held <= 1'b1;
                wready <= 1'b0;
            end
            if (aw_held && w_held && !bvalid) begin
                bvalid <= 1'b1;
                bresp <= (aw_addr_q <= timer_channel_pkg::CONTROL_OFFSET
                          && aw_addr_q[1:0] == 2'h0)
                    ? timer_channel_pkg::RESP_OKAY
                    : timer_channel_pkg::RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    wire write_now = aw_held && w_held && !bvalid;

    // configuration registers; hardware output events win over writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= timer_channel_pkg::mode_type'(timer_channel_pkg::MODE_RESET);
            out_mode <= timer_channel_pkg::OUT_RESET;
            out_level <= timer_channel_pkg::OUT_RESET;
            out_value <= timer_channel_pkg::OUT_RESET;
            out_enable <= timer_channel_pkg::OUT_RESET;
            in_filter <= timer_channel_pkg::FILTER_RESET;
            data <= COUNT_WIDTH'(timer_channel_pkg::DATA_RESET);
            sw_start <= 1'b0;
            sw_stop <= 1'b0;
        end else begin
            sw_start <= 1'b0;
            sw_stop <= 1'b0;
            if (write_now) begin
                wr_word_apply();
            end
            if (evt_toggle) begin
                out_value[CHANNEL] <= ~out_value[CHANNEL];
            end else if (evt_set) begin
                out_value[CHANNEL] <= 1'b1;
            end else if (evt_clear) begin
                out_value[CHANNEL] <= 1'b0;
            end
            if (do_capture) begin
                data <= count;
            end
        end
    end

    task automatic wr_word_apply();
        if (aw_addr_q == timer_channel_pkg::MODE_OFFSET) begin
            mode <= timer_channel_pkg::mode_type'(wr_word[15:0]);
        end else if (aw_addr_q == timer_channel_pkg::OUT_MODE_OFFSET) begin
            out_mode <= wr_word[15:0];
        end else if (aw_addr_q == timer_channel_pkg::OUT_LEVEL_OFFSET) begin
            out_level <= wr_word[15:0];
        end else if (aw_addr_q == timer_channel_pkg::OUT_VALUE_OFFSET) begin
            out_value <= wr_word[15:0];
        end else if (aw_addr_q == timer_channel_pkg::OUT_ENABLE_OFFSET) begin
            out_enable <= wr_word[15:0];
        end else if (aw_addr_q == timer_channel_pkg::IN_FILTER_OFFSET) begin
            in_filter <= wr_word[7:0];
        end else if (aw_addr_q == timer_channel_pkg::DATA_OFFSET) begin
            data <= wr_word[COUNT_WIDTH-1:0];
        end else if (aw_addr_q == timer_channel_pkg::CONTROL_OFFSET) begin
            sw_start <= wr_word[timer_channel_pkg::CTRL_START_BIT];
            sw_stop <= wr_word[timer_channel_pkg::CTRL_STOP_BIT];
        end
    endtask : wr_word_apply

    always_comb begin
        wr_word = 32'h0000_0000;
        if (aw_addr_q == timer_channel_pkg::MODE_OFFSET) begin
            wr_word = merge({16'h0000, mode}, w_data_q, w_strb_q);
        end else if (aw_addr_q == timer_channel_pkg::DATA_OFFSET) begin
            wr_word = merge(32'(data), w_data_q, w_strb_q);
        end else begin
            wr_word = merge(rd_word_of(aw_addr_q), w_data_q, w_strb_q);
        end
    end

    function automatic logic [31:0] rd_word_of(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == timer_channel_pkg::OUT_MODE_OFFSET) begin
            v = {16'h0000, out_mode};
        end else if (a == timer_channel_pkg::OUT_LEVEL_OFFSET) begin
            v = {16'h0000, out_level};
        end else if (a == timer_channel_pkg::OUT_VALUE_OFFSET) begin
            v = {16'h0000, out_value};
        end else if (a == timer_channel_pkg::OUT_ENABLE_OFFSET) begin
            v = {16'h0000, out_enable};
        end else if (a == timer_channel_pkg::IN_FILTER_OFFSET) begin
            v = {24'h000000, in_filter};
        end
        return v;
    endfunction : rd_word_of

    // read channel: one word per request, unmapped answers SLVERR
    always_comb begin
        rd_ok = 1'b1;
        rd_word = rd_word_of(araddr);
        if (araddr == timer_channel_pkg::MODE_OFFSET) begin
            rd_word = {16'h0000, mode};
        end else if (araddr == timer_channel_pkg::DATA_OFFSET) begin
            rd_word = 32'(data);
        end else if (araddr == timer_channel_pkg::COUNT_OFFSET) begin
            rd_word = 32'(count);
        end else if (araddr == timer_channel_pkg::CONTROL_OFFSET) begin
            rd_word[timer_channel_pkg::STAT_COUNT_BIT] =
                (state == timer_channel_pkg::ST_COUNT);
            rd_word[timer_channel_pkg::STAT_WAIT_BIT] =
                (state == timer_channel_pkg::ST_WAIT);
        end else if (araddr > timer_channel_pkg::CONTROL_OFFSET
                     || araddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= timer_channel_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_ok ? timer_channel_pkg::RESP_OKAY
                           : timer_channel_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc <= 16'h0000;
        end else begin
            presc <= presc + 16'h0001;
        end
    end

    // input pin: three stages, the level moves when stages two and three
    // agree; the filter also asks for that agreement to last
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync <= 3'h0;
            in_level <= 1'b0;
            in_prev <= 1'b0;
            filt_cnt <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], timer_input_pin};
            in_prev <= in_level;
            if (pin_sync[2] != pin_sync[1] || pin_sync[2] == in_level) begin
                filt_cnt <= 2'h0;
            end else if (!in_filter[CHANNEL]
                         || filt_cnt == timer_channel_pkg::FILTER_SAMPLES) begin
                in_level <= pin_sync[2];
                filt_cnt <= 2'h0;
            end else if (op_tick) begin
                filt_cnt <= filt_cnt + 2'h1;
            end
        end
    end

    assign rise = in_level && !in_prev;
    assign fall = !in_level && in_prev;

    always_comb begin
        case ({mode.op_clock_select_hi, mode.op_clock_select_lo})
            2'b00: op_tick = tick_at(presc, CK0_SHIFT);
            2'b01: op_tick = tick_at(presc, CK2_SHIFT);
            2'b10: op_tick = tick_at(presc, CK1_SHIFT);
            default: op_tick = tick_at(presc, CK3_SHIFT);
        endcase
        // valid edge and width-measure edge pairs
        case (edge_sel)
            timer_channel_pkg::EDGE_FALL: begin
                valid_edge = fall;
                start_edge = fall;
                capture_edge = fall;
            end
            timer_channel_pkg::EDGE_RISE: begin
                valid_edge = rise;
                start_edge = rise;
                capture_edge = rise;
            end
            timer_channel_pkg::EDGE_BOTH_LOW: begin
                valid_edge = rise || fall;
                start_edge = fall;
                capture_edge = rise;
            end
            default: begin
                valid_edge = rise || fall;
                start_edge = rise;
                capture_edge = fall;
            end
        endcase
        count_tick = mode.count_clock_source ? valid_edge : op_tick;
        // trigger source; prohibited codes give none
        case (trig_sel)
            timer_channel_pkg::TRIG_VALID_EDGE: begin
                start_trig = valid_edge;
                capture_trig = valid_edge;
            end
            timer_channel_pkg::TRIG_BOTH_EDGES: begin
                start_trig = start_edge;
                capture_trig = capture_edge;
            end
            timer_channel_pkg::TRIG_MASTER: begin
                start_trig = master_irq_in;
                capture_trig = master_irq_in;
            end
            default: begin
                start_trig = 1'b0;
                capture_trig = 1'b0;
            end
        endcase
    end

    // channel sequencing
    always_comb begin
        next_state = state;
        next_count = count;
        evt_irq = 1'b0;
        do_capture = 1'b0;
        evt_set = 1'b0;
        evt_clear = 1'b0;
        case (state)
            timer_channel_pkg::ST_IDLE: begin
                if (sw_start) begin
                    case (op_mode)
                        timer_channel_pkg::MODE_INTERVAL,
                        timer_channel_pkg::MODE_EVENT: begin
                            next_count = data;
                            next_state = timer_channel_pkg::ST_COUNT;
                            evt_irq = mode.start_control_bit;
                        end
                        timer_channel_pkg::MODE_CAPTURE: begin
                            next_count = COUNT_ZERO;
                            next_state = timer_channel_pkg::ST_COUNT;
                            evt_irq = mode.start_control_bit;
                        end
                        timer_channel_pkg::MODE_ONE_COUNT,
                        timer_channel_pkg::MODE_CAPTURE_ONE: begin
                            next_state = timer_channel_pkg::ST_WAIT;
                        end
                        default: next_state = timer_channel_pkg::ST_IDLE;
                    endcase
                end
            end
            timer_channel_pkg::ST_WAIT: begin
                if (start_trig || sw_start) begin
                    next_state = timer_channel_pkg::ST_COUNT;
                    if (op_mode == timer_channel_pkg::MODE_ONE_COUNT) begin
                        next_count = data;
                        evt_set = 1'b1;
                    end else begin
                        next_count = COUNT_ZERO;
                        // no start interrupt when control bit is 0
                        evt_irq = mode.start_control_bit;
                    end
                end
            end
            default: begin
                case (op_mode)
                    timer_channel_pkg::MODE_ONE_COUNT: begin
                        // retrigger only with control bit set
                        if (start_trig && mode.start_control_bit) begin
                            next_count = data;
                        end else if (count_tick) begin
                            if (count == COUNT_ZERO) begin
                                evt_irq = 1'b1;
                                evt_clear = 1'b1;
                                next_state = timer_channel_pkg::ST_WAIT;
                            end else begin
                                next_count = count - COUNT_ONE;
                            end
                        end
                    end
                    timer_channel_pkg::MODE_CAPTURE,
                    timer_channel_pkg::MODE_CAPTURE_ONE: begin
                        if (capture_trig) begin
                            do_capture = 1'b1;
                            evt_irq = 1'b1;
                            next_count = COUNT_ZERO;
                            if (op_mode == timer_channel_pkg::MODE_CAPTURE_ONE) begin
                                next_state = timer_channel_pkg::ST_WAIT;
                            end
                        end else if (count_tick) begin
                            next_count = count + COUNT_ONE;
                        end
                    end
                    default: begin
                        if (count_tick) begin
                            if (count == COUNT_ZERO) begin
                                evt_irq = 1'b1;
                                next_count = data;
                            end else begin
                                next_count = count - COUNT_ONE;
                            end
                        end
                    end
                endcase
            end
        endcase
        if (sw_stop) begin
            next_state = timer_channel_pkg::ST_IDLE;
            evt_irq = 1'b0;
            do_capture = 1'b0;
            evt_set = 1'b0;
            evt_clear = 1'b0;
        end
    end

    // out_mode bit clear toggles on interrupts when output enabled, one-count mode sets and clears
    assign evt_toggle = evt_irq && !out_mode[CHANNEL] && out_enable[CHANNEL];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= timer_channel_pkg::ST_IDLE;
            count <= COUNT_ZERO;
            timer_irq <= 1'b0;
            master_irq_out <= 1'b0;
            timer_out <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            timer_irq <= evt_irq;
            // master role passes the interrupt on
            master_irq_out <= evt_irq && mode.master;
            // level inverts, enable gates the pin
            timer_out <= out_enable[CHANNEL]
                && (out_value[CHANNEL] ^ out_level[CHANNEL]);
        end
    end

endmodule : timer_channel_pulse_capture

// ---- test/timer_channel_chk.sv ----
// checker: bus handshake and interrupt relations at the channel ports
// assumes a bind into the channel, one clock domain
`timescale 1ns/1ps
module timer_channel_chk (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic rvalid, // r valid
    input wire logic rready, // r ready
    input wire logic timer_irq, // interrupt
    input wire logic master_irq_out // master interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered next cycle");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready
        |-> ##2 bvalid) else $error("write not answered");
    b_release_a: assert property (bvalid && bready |=> !bvalid && awready)
        else $error("write response not released");
    r_release_a: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read response not released");
    w_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    r_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while response pending");
    irq_pulse_a: assert property (timer_irq |=> !timer_irq)
        else $error("interrupt wider than one cycle");
    mirq_gate_a: assert property (
        master_irq_out |-> timer_irq || $past(timer_irq))
        else $error("master interrupt without channel interrupt");
    cover property (timer_irq);
    cover property (master_irq_out);
    cover property (bvalid && bready);
endmodule : timer_channel_chk
bind timer_channel_pulse_capture timer_channel_chk u_timer_channel_chk (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .arvalid, .arready, .rvalid, .rready, .timer_irq, .master_irq_out);

// ---- test/timer_input_source.sv ----
// pulse source standing in for the signal on the timer input pin
// assumes the bench calls fire from its own process
`timescale 1ns/1ps
module timer_input_source (
    input wire logic aclk, // bench clock
    output logic pin // pulse to the timer input pin
);
    initial pin = 1'b0;
    // one period is hi plus lo cycles, rising edge first
    task automatic fire(input int hi, input int lo);
        @(posedge aclk);
        pin <= 1'b1;
        repeat (hi) @(posedge aclk);
        pin <= 1'b0;
        repeat (lo - 1) @(posedge aclk);
    endtask : fire
endmodule : timer_input_source

// ---- test/timer_channel_pulse_capture_tb.sv ----
// bench: registers, capture per clock select, output pin levels
// assumes the channel, its checker and the pulse source compiled first
`timescale 1ns/1ps
module timer_channel_pulse_capture_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, pin, awready, wready, bvalid, arready;
    logic rvalid, timer_out, timer_irq, master_irq_out;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_val;
    logic [1:0] bresp, rresp, rsp;
    int fails = 0, checked = 0, cyc = 0, irqs = 0, mirqs = 0;
    int shifts[4] = '{1, 3, 2, 4};
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        irqs <= irqs + int'(timer_irq);
        mirqs <= mirqs + int'(master_irq_out);
        if (cyc == 40000) begin
            fails++;
            test_done();
        end
    end
    timer_channel_pulse_capture u_timer_channel_pulse_capture (.aclk,
        .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .timer_input_pin(pin), .master_irq_in(1'b0), .timer_out, .timer_irq,
        .master_irq_out);
    timer_input_source u_timer_input_source (.aclk, .pin);
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_val = rdata;
        rsp = rresp;
    endtask : rd
    task automatic t_regs;
        rd(timer_channel_pkg::MODE_OFFSET);
        chk("mode reset", 32'h0, rd_val);
        wr(timer_channel_pkg::MODE_OFFSET, 32'hFFFF_C104);
        rd(timer_channel_pkg::MODE_OFFSET);
        chk("mode", 32'h0000_C104, rd_val);
        wr(8'h24, 32'h1);
        chk("unmapped write", 32'h2, {30'h0, rsp});
        rd(8'h24);
        chk("unmapped read", 32'h2, {30'h0, rsp} | rd_val);
        $display("test regs done");
    endtask : t_regs
    task automatic t_capture(input int sel);
        logic m, sc;
        logic [15:0] mode;
        int i0, m0;
        m = (sel == 3);
        sc = (sel == 1);
        // capture on rising edges, sel 0 is clock zero
        mode = 16'h0144 | (16'(sel) << 14) | (16'(m) << 11) | 16'(sc);
        wr(timer_channel_pkg::CONTROL_OFFSET, 32'h2);
        wr(timer_channel_pkg::MODE_OFFSET, {16'h0, mode});
        i0 = irqs;
        m0 = mirqs;
        wr(timer_channel_pkg::CONTROL_OFFSET, 32'h1);
        // the interrupt counters lag the pulse by one edge
        repeat (2) @(posedge aclk);
        chk("start irq", 32'(sc), 32'(irqs - i0));
        repeat (3) u_timer_input_source.fire(80, 80);
        rd(timer_channel_pkg::DATA_OFFSET);
        chk("capture", 1, rd_val + 1 - (160 >> shifts[sel]) <= 1);
        chk("capture irqs", 32'(sc) + 3, 32'(irqs - i0));
        chk("master irqs", 32'(m) * 3, 32'(mirqs - m0));
        if (m) begin
            // a short glitch must not pass two slow filter samples
            wr(timer_channel_pkg::IN_FILTER_OFFSET, 32'h4);
            i0 = irqs;
            u_timer_input_source.fire(4, 40);
            chk("filtered glitch", 0, 32'(irqs - i0));
        end
        $display("test capture %0d done", sel);
    endtask : t_capture
    task automatic t_out;
        for (int i = 0; i < 8; i++) begin
            wr(timer_channel_pkg::OUT_LEVEL_OFFSET, 32'(i[0]) << 2);
            wr(timer_channel_pkg::OUT_VALUE_OFFSET, 32'(i[1]) << 2);
            wr(timer_channel_pkg::OUT_ENABLE_OFFSET, 32'(i[2]) << 2);
            repeat (3) @(posedge aclk);
            chk("timer_out", i[2] & (i[0] ^ i[1]), timer_out);
        end
        $display("test output done");
    endtask : t_out
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        for (int s = 0; s < 4; s++) t_capture(s);
        t_out();
        test_done();
    end
endmodule : timer_channel_pulse_capture_tb
